// ===== design/cpm_avg.sv
// running average over the newest 1, 2, 4 or 8 samples
`timescale 1ns/100ps
module cpm_avg (
  input  wire logic               sys_clk_i,
  input  wire logic               reset_n_i,
  input  wire logic               push_i,
  input  wire logic signed [11:0] sample_i,
  input  wire logic [1:0]         avg_code_i,
  output logic signed [11:0]      avg_o
);
  logic signed [11:0] hist_q [8];
  logic signed [11:0] hist_d [8];
  logic signed [14:0] sum;
  logic signed [11:0] avg_d;
  int                 n;

  always_comb
  begin
    n   = 1 << avg_code_i;
    sum = 15'(sample_i);
    for (int i = 0; i < 7; i++)
    begin
      if (i < n - 1)
      begin
        sum = sum + 15'(hist_q[i]);
      end
    end
    avg_d  = push_i ? 12'(sum >>> avg_code_i) : avg_o;
    hist_d = hist_q;
    if (push_i)
    begin
      hist_d[0] = sample_i;
      for (int i = 1; i < 8; i++)
      begin
        hist_d[i] = hist_q[i-1];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      hist_q <= '{default: 12'h000};
      avg_o  <= 12'h000;
    end
    else
    begin
      hist_q <= hist_d;
      avg_o  <= avg_d;
    end
  end
endmodule : cpm_avg

// ===== design/cpm_pkg.sv
// shared constants, types and helpers of the current/power monitor sequencer
package cpm_pkg;
  localparam int NCH            = 2;
  localparam int NMEAS          = 2 * NCH;
  localparam int MEAS_SENSE     = 0;
  localparam int MEAS_SOURCE    = 1;
  localparam int FLG_CONVERSION_DONE_FLAG  = NMEAS;
  localparam int SENSE_W        = 12;
  localparam int SOURCE_W       = 11;
  localparam int RESULT_W       = 16;
  localparam int SENSE_PAD      = 4;
  localparam int SOURCE_PAD     = 5;
  localparam int SENSE_BITS_MIN = 6;
  localparam int SENSE_BITS_MAX = 11;
  localparam int SOURCE_BITS_MIN = 8;
  localparam int RATIO_SHIFT    = 6;

  localparam int CLK_PERIOD_NS  = 50;
  localparam int TICK_TIME_US   = 2500;
  localparam int TICK_CYCLES    = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int RATE_1_MS      = 1000;
  localparam int RATE_2_MS      = 500;
  localparam int RATE_4_MS      = 250;
  localparam logic [8:0] PERIOD_1_TICKS = 9'((RATE_1_MS * 1000) / TICK_TIME_US);
  localparam logic [8:0] PERIOD_2_TICKS = 9'((RATE_2_MS * 1000) / TICK_TIME_US);
  localparam logic [8:0] PERIOD_4_TICKS = 9'((RATE_4_MS * 1000) / TICK_TIME_US);
  localparam int ALERT_PULSE_NS = 5000;
  localparam logic [6:0] ALERT_PULSE_CYCLES =
    7'((ALERT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [2:0] SENSE_TIME_RST  = 3'h5;
  localparam logic [1:0] SOURCE_TIME_RST = 2'h2;
  localparam logic [1:0] AVG_RST         = 2'h0;
  localparam logic [1:0] RANGE_RST       = 2'h3;
  localparam logic [1:0] RATE_RST        = 2'h3;
  localparam logic [1:0] RATE_1          = 2'h0;
  localparam logic [1:0] RATE_2          = 2'h1;
  localparam logic [1:0] RATE_4          = 2'h2;

  typedef enum logic [1:0] {ST_STANDBY, ST_SAMPLE, ST_FINISH, ST_WAIT} cpm_state_e;
  typedef enum logic [1:0] {PH_SENSE, PH_SOURCE, PH_DONE} cpm_phase_e;

  // sample windows in 2.5 ms ticks, doubling per code step
  function automatic logic [7:0] sense_ticks(input logic [2:0] code);
    return 8'h01 << code;
  endfunction : sense_ticks

  function automatic logic [7:0] source_ticks(input logic [1:0] code);
    return 8'h01 << code;
  endfunction : source_ticks

  // zero means back-to-back cycles
  function automatic logic [8:0] period_ticks(input logic [1:0] rate);
    unique case (rate)
      RATE_1:  return PERIOD_1_TICKS;
      RATE_2:  return PERIOD_2_TICKS;
      RATE_4:  return PERIOD_4_TICKS;
      default: return 9'h000;
    endcase
  endfunction : period_ticks

  // keeps sign plus 6..11 magnitude bits, depending on window length
  function automatic logic [11:0] sense_mask(input logic [2:0] code);
    int bits;
    bits = SENSE_BITS_MIN + int'(code);
    if (bits > SENSE_BITS_MAX)
    begin
      bits = SENSE_BITS_MAX;
    end
    return 12'hfff << (SENSE_BITS_MAX - bits);
  endfunction : sense_mask

  function automatic logic [10:0] source_mask(input logic [1:0] code);
    return 11'h7ff << (SOURCE_W - SOURCE_BITS_MIN - int'(code));
  endfunction : source_mask

  // |sense| * |source|, top 16 bits of the 22-bit product
  function automatic logic [15:0] power_ratio(input logic [11:0] s,
                                              input logic [10:0] v);
    logic [10:0] m;
    logic [21:0] p;
    m = s[11] ? 11'(~s + 12'h001) : s[10:0];
    if (s == 12'h800)
    begin
      m = 11'h7ff;
    end
    p = 22'(m) * 22'(v);
    return p[21:RATIO_SHIFT];
  endfunction : power_ratio
endpackage : cpm_pkg

// ===== design/cpm_sequencer.sv
// conversion sequencer: power states, sampling windows, results, limits, alert
// Functional notes
// - active: cycles start automatically at the programmed rate interval
// - standby: no cycles run, stored results stay readable
// - all measurement disables set puts the device into standby
// - standby one-shot request runs one cycle, then back to standby
// - active skips disabled measurements; one-shot updates every measurement
// - both channels start sampling at the same instant
// - sense window first, then source window, each with its own time
// - optional averaging of last 2..8 samples, per measurement and channel
// - cycle end updates enabled results, ratio, high/low status, done flag
// - cycle end asserts alert when a value is out of its limits
// - rate selectable in active, slowest one cycle per second
// - sampling longer than the rate period forces continuous cycles
// - sense resolution is sign plus 6..11 bits by window length
// - sense result signed, left-justified, low four bits zero
// - four sense ranges, widest after reset
// - source result unsigned, left-justified, low five bits zero
// - ratio is |sense| times |source| kept as 16 bits
// - ratio recomputed whenever a channel result updates
// - ratio 65535 stands for full-scale power
// - sense time code 2.5..320 ms doubling, 80 ms after reset
// - source time code 2.5..20 ms, 10 ms after reset
// - alert holds after the condition goes until flags are cleared
`timescale 1ns/100ps
module cpm_sequencer #(
  parameter int unsigned TICK_CYCLES = cpm_pkg::TICK_CYCLES
) (
  input  wire logic                                 sys_clk_i,
  input  wire logic                                 reset_n_i,
  input  wire logic [cpm_pkg::NMEAS-1:0]            measurement_disable_flags_i,
  input  wire logic                                 one_shot_req_i,
  input  wire logic [1:0]                           conversion_rate_setting_i,
  input  wire logic [cpm_pkg::NCH-1:0][2:0]         sense_sample_time_code_i,
  input  wire logic [cpm_pkg::NCH-1:0][1:0]         source_sample_time_code_i,
  input  wire logic [cpm_pkg::NCH-1:0][1:0]         sense_avg_code_i,
  input  wire logic [cpm_pkg::NCH-1:0][1:0]         source_avg_code_i,
  input  wire logic [1:0]                           full_scale_range_i,
  input  wire logic [cpm_pkg::NCH-1:0][11:0]        sense_raw_i,
  input  wire logic [cpm_pkg::NCH-1:0][10:0]        source_raw_i,
  input  wire logic [cpm_pkg::NCH-1:0][11:0]        sense_high_limit_i,
  input  wire logic [cpm_pkg::NCH-1:0][11:0]        sense_low_limit_i,
  input  wire logic [cpm_pkg::NCH-1:0][10:0]        source_high_limit_i,
  input  wire logic [cpm_pkg::NCH-1:0][10:0]        source_low_limit_i,
  input  wire logic [cpm_pkg::NMEAS:0]              high_status_clear_i,
  input  wire logic [cpm_pkg::NMEAS-1:0]            low_status_clear_i,
  input  wire logic                                 alert_mask_all_i,
  input  wire logic [cpm_pkg::NMEAS-1:0]            alert_mask_i,
  input  wire logic                                 conversion_done_flag_alert_en_i,
  output logic [1:0]                                full_scale_range_o,
  output logic [cpm_pkg::NCH-1:0]                   sample_sense_o,
  output logic [cpm_pkg::NCH-1:0]                   sample_source_o,
  output logic                                      standby_o,
  output logic                                      busy_o,
  output logic [cpm_pkg::NCH-1:0][15:0]             sense_result_o,
  output logic [cpm_pkg::NCH-1:0][15:0]             source_result_o,
  output logic [cpm_pkg::NCH-1:0][15:0]             power_ratio_o,
  output logic [cpm_pkg::NMEAS:0]                   high_status_o,
  output logic [cpm_pkg::NMEAS-1:0]                 low_status_o,
  output logic                                      alert_o,
  output logic                                      alert_oe_n_o
);
  import cpm_pkg::*;

  cpm_state_e             state_q, state_d;
  cpm_phase_e             phase_q [NCH];
  cpm_phase_e             phase_d [NCH];
  logic [NCH-1:0][7:0]    tcnt_q, tcnt_d;
  logic [8:0]             per_q, per_d;
  logic                   shot_q, shot_d;
  logic [NMEAS-1:0]       en_q, en_d;
  logic [NCH-1:0][2:0]    stime_q, stime_d;
  logic [NCH-1:0][1:0]    vtime_q, vtime_d;
  logic [NCH-1:0][1:0]    savg_q, savg_d;
  logic [NCH-1:0][1:0]    vavg_q, vavg_d;
  logic [1:0]             range_d;
  logic [1:0]             rate_q, rate_d;
  logic [NCH-1:0]         push_s, push_v;
  logic [NCH-1:0]         ss_d, sv_d;
  logic [NCH-1:0][11:0]   savg_out;
  logic [NCH-1:0][11:0]   vavg_out;
  logic                   start, finish, tick, all_dis, all_done, override;
  logic [8:0]             win;

  cpm_tick_div #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .restart_i (start),
    .tick_o    (tick)
  );

  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    cpm_avg u_savg (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .push_i     (push_s[c]),
      .sample_i   (sense_raw_i[c] & sense_mask(stime_q[c])),
      .avg_code_i (savg_q[c]),
      .avg_o      (savg_out[c])
    );
    cpm_avg u_vavg (
      .sys_clk_i  (sys_clk_i),
      .reset_n_i  (reset_n_i),
      .push_i     (push_v[c]),
      .sample_i   ({1'b0, source_raw_i[c] & source_mask(vtime_q[c])}),
      .avg_code_i (vavg_q[c]),
      .avg_o      (vavg_out[c])
    );
  end

  always_comb
  begin
    state_d  = state_q;
    phase_d  = phase_q;
    tcnt_d   = tcnt_q;
    per_d    = per_q;
    shot_d   = shot_q;
    en_d     = en_q;
    stime_d  = stime_q;
    vtime_d  = vtime_q;
    savg_d   = savg_q;
    vavg_d   = vavg_q;
    range_d  = full_scale_range_o;
    rate_d   = rate_q;
    push_s   = '0;
    push_v   = '0;
    start    = 1'b0;
    finish   = 1'b0;
    all_done = 1'b1;
    override = 1'b0;
    all_dis  = &measurement_disable_flags_i;
    for (int c = 0; c < NCH; c++)
    begin
      win = 9'(sense_ticks(stime_q[c])) + 9'(source_ticks(vtime_q[c]));
      if (win > period_ticks(rate_q))
      begin
        override = 1'b1;
      end
    end
    if (tick && per_q != 9'h1ff)
    begin
      per_d = per_q + 9'h001;
    end
    unique case (state_q)
      ST_STANDBY:
      begin
        per_d = per_q;
        if (one_shot_req_i || !all_dis)
        begin
          start = 1'b1;
        end
      end
      ST_SAMPLE:
      begin
        for (int c = 0; c < NCH; c++)
        begin
          unique case (phase_q[c])
            PH_SENSE:
            begin
              if (!en_q[2*c+MEAS_SENSE])
              begin
                phase_d[c] = PH_SOURCE;
              end
              else if (tick)
              begin
                tcnt_d[c] = tcnt_q[c] + 8'h01;
                if (tcnt_d[c] == sense_ticks(stime_q[c]))
                begin
                  push_s[c]  = 1'b1;
                  phase_d[c] = PH_SOURCE;
                  tcnt_d[c]  = 8'h00;
                end
              end
            end
            PH_SOURCE:
            begin
              if (!en_q[2*c+MEAS_SOURCE])
              begin
                phase_d[c] = PH_DONE;
              end
              else if (tick)
              begin
                tcnt_d[c] = tcnt_q[c] + 8'h01;
                if (tcnt_d[c] == source_ticks(vtime_q[c]))
                begin
                  push_v[c]  = 1'b1;
                  phase_d[c] = PH_DONE;
                  tcnt_d[c]  = 8'h00;
                end
              end
            end
            PH_DONE:
            begin
              tcnt_d[c] = 8'h00;
            end
          endcase
          if (phase_q[c] != PH_DONE)
          begin
            all_done = 1'b0;
          end
        end
        if (all_done)
        begin
          state_d = ST_FINISH;
        end
      end
      ST_FINISH:
      begin
        finish  = 1'b1;
        state_d = (shot_q || all_dis) ? ST_STANDBY : ST_WAIT;
      end
      ST_WAIT:
      begin
        if (all_dis)
        begin
          state_d = ST_STANDBY;
        end
        else if (override || per_d >= period_ticks(rate_q))
        begin
          start = 1'b1;
        end
      end
    endcase
    if (start)
    begin
      // settings are frozen for the whole cycle so a cycle never mixes codes
      state_d = ST_SAMPLE;
      tcnt_d  = '0;
      per_d   = 9'h000;
      shot_d  = all_dis;
      en_d    = all_dis ? '1 : ~measurement_disable_flags_i;
      stime_d = sense_sample_time_code_i;
      vtime_d = source_sample_time_code_i;
      savg_d  = sense_avg_code_i;
      vavg_d  = source_avg_code_i;
      range_d = full_scale_range_i;
      rate_d  = conversion_rate_setting_i;
      for (int c = 0; c < NCH; c++)
      begin
        // a channel with its sense off opens its source window at once
        phase_d[c] = en_d[2*c+MEAS_SENSE] ? PH_SENSE : PH_SOURCE;
      end
    end
    for (int c = 0; c < NCH; c++)
    begin
      ss_d[c] = (state_d == ST_SAMPLE) && (phase_d[c] == PH_SENSE) && en_d[2*c];
      sv_d[c] = (state_d == ST_SAMPLE) && (phase_d[c] == PH_SOURCE) && en_d[2*c+1];
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q            <= ST_STANDBY;
      phase_q            <= '{default: PH_DONE};
      tcnt_q             <= '0;
      per_q              <= 9'h000;
      shot_q             <= 1'b0;
      en_q               <= '0;
      stime_q            <= {NCH{SENSE_TIME_RST}};
      vtime_q            <= {NCH{SOURCE_TIME_RST}};
      savg_q             <= {NCH{AVG_RST}};
      vavg_q             <= {NCH{AVG_RST}};
      full_scale_range_o <= RANGE_RST;
      rate_q             <= RATE_RST;
      sample_sense_o     <= '0;
      sample_source_o    <= '0;
      standby_o          <= 1'b1;
      busy_o             <= 1'b0;
    end
    else
    begin
      state_q            <= state_d;
      phase_q            <= phase_d;
      tcnt_q             <= tcnt_d;
      per_q              <= per_d;
      shot_q             <= shot_d;
      en_q               <= en_d;
      stime_q            <= stime_d;
      vtime_q            <= vtime_d;
      savg_q             <= savg_d;
      vavg_q             <= vavg_d;
      full_scale_range_o <= range_d;
      rate_q             <= rate_d;
      sample_sense_o     <= ss_d;
      sample_source_o    <= sv_d;
      standby_o          <= (state_d == ST_STANDBY);
      busy_o             <= (state_d == ST_SAMPLE) || (state_d == ST_FINISH);
    end
  end

  logic [NCH-1:0][15:0] sres_d, vres_d, ratio_d;
  logic [NMEAS:0]       hi_d, hi_set;
  logic [NMEAS-1:0]     lo_d, lo_set;
  logic [6:0]           pulse_q, pulse_d;
  logic                 alert_d;

  always_comb
  begin
    sres_d  = sense_result_o;
    vres_d  = source_result_o;
    ratio_d = power_ratio_o;
    hi_set  = '0;
    lo_set  = '0;
    pulse_d = (pulse_q != 7'h00) ? pulse_q - 7'h01 : 7'h00;
    if (finish)
    begin
      for (int c = 0; c < NCH; c++)
      begin
        if (en_q[2*c+MEAS_SENSE])
        begin
          sres_d[c] = {savg_out[c], 4'h0};
        end
        if (en_q[2*c+MEAS_SOURCE])
        begin
          vres_d[c] = {vavg_out[c][10:0], 5'h00};
        end
        // full scale on both gives near 65535
        ratio_d[c] = power_ratio(sres_d[c][15:4], vres_d[c][15:5]);
        hi_set[2*c] = $signed(sres_d[c][15:4]) >= $signed(sense_high_limit_i[c]);
        lo_set[2*c] = $signed(sres_d[c][15:4]) < $signed(sense_low_limit_i[c]);
        hi_set[2*c+1] = vres_d[c][15:5] >= source_high_limit_i[c];
        lo_set[2*c+1] = vres_d[c][15:5] < source_low_limit_i[c];
      end
      hi_set[FLG_CONVERSION_DONE_FLAG] = 1'b1;
      if (conversion_done_flag_alert_en_i)
      begin
        pulse_d = ALERT_PULSE_CYCLES;
      end
    end
    // a flag set in the clearing cycle survives
    hi_d    = (high_status_o & ~high_status_clear_i) | hi_set;
    lo_d    = (low_status_o & ~low_status_clear_i) | lo_set;
    alert_d = !alert_mask_all_i &&
              (|((hi_d[NMEAS-1:0] | lo_d) & ~alert_mask_i));
    alert_d = alert_d || (pulse_d != 7'h00);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sense_result_o  <= '0;
      source_result_o <= '0;
      power_ratio_o   <= '0;
      high_status_o   <= '0;
      low_status_o    <= '0;
      pulse_q         <= 7'h00;
      alert_o         <= 1'b0;
      alert_oe_n_o    <= 1'b1;
    end
    else
    begin
      sense_result_o  <= sres_d;
      source_result_o <= vres_d;
      power_ratio_o   <= ratio_d;
      high_status_o   <= hi_d;
      low_status_o    <= lo_d;
      pulse_q         <= pulse_d;
      alert_o         <= 1'b0;
      alert_oe_n_o    <= !alert_d;
    end
  end
endmodule : cpm_sequencer

// ===== design/cpm_tick_div.sv
// fixed time base: one-cycle tick every 2.5 ms, restartable
`timescale 1ns/100ps
module cpm_tick_div #(
  parameter int unsigned TICK_CYCLES = 50000
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic restart_i,
  output logic      tick_o
);
  localparam int CW = $clog2(TICK_CYCLES + 1);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    if (restart_i)
    begin
      cnt_d = '0;
    end
    else if (cnt_q == CW'(TICK_CYCLES - 1))
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_q  <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_o <= tick_d;
    end
  end
endmodule : cpm_tick_div

// ===== test/cpm_front_model.sv
// behavioural analog front end presenting bench levels as raw samples
`timescale 1ns/100ps
module cpm_front_model (
  input  wire logic                          sys_clk_i,
  input  wire logic [cpm_pkg::NCH-1:0][11:0] sense_lvl_i,
  input  wire logic [cpm_pkg::NCH-1:0][10:0] source_lvl_i,
  output logic [cpm_pkg::NCH-1:0][11:0]      sense_raw_o,
  output logic [cpm_pkg::NCH-1:0][10:0]      source_raw_o
);
  import cpm_pkg::*;
  // updates off the rising edge so a sampling tick never sees a half-changed level
  always_ff @(negedge sys_clk_i)
  begin
    sense_raw_o  <= sense_lvl_i;
    source_raw_o <= source_lvl_i;
  end
endmodule : cpm_front_model

// ===== test/cpm_sequencer_bench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module cpm_sequencer_bench;
  import cpm_pkg::*;
  localparam int TICKS = 4;
  int                   fails = 0;
  int                   samples_checked = 0;
  logic                 sys_clk_i = 1'b0;
  logic                 reset_n_i = 1'b0;
  logic [3:0]           dis = 4'hf;
  logic                 osr = 1'b0;
  logic [1:0]           rate = 2'h3;
  logic [1:0][2:0]      stc = '0;
  logic [1:0][1:0]      vtc = '0;
  logic [1:0][1:0]      vavg = '0;
  logic [1:0]           full_scale_range = 2'h1;
  logic [1:0][11:0]     slvl = {12'hc00, 12'h41f};
  logic [1:0][10:0]     vlvl = {11'h407, 11'h407};
  logic [1:0][11:0]     shl = {12'h7ff, 12'h7ff};
  logic [1:0][10:0]     vll = '0;
  logic [4:0]           hclr = '0;
  logic [3:0]           lclr = '0;
  logic                 mall = 1'b0;
  logic                 cdae = 1'b0;
  logic [1:0][11:0]     sraw;
  logic [1:0][10:0]     vraw;
  logic [1:0]           fso, ss, vs;
  logic                 stby, busy, alrt, aoen;
  logic [1:0][15:0]     sres, vres, pr;
  logic [4:0]           hst;
  logic [3:0]           lst;

  initial
  begin
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  cpm_front_model u_cpm_front_model (.sys_clk_i(sys_clk_i), .sense_lvl_i(slvl),
    .source_lvl_i(vlvl), .sense_raw_o(sraw), .source_raw_o(vraw));

  cpm_sequencer #(.TICK_CYCLES(TICKS)) u_cpm_sequencer (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .measurement_disable_flags_i(dis), .one_shot_req_i(osr),
    .conversion_rate_setting_i(rate), .sense_sample_time_code_i(stc),
    .source_sample_time_code_i(vtc), .sense_avg_code_i(4'h0), .source_avg_code_i(vavg),
    .full_scale_range_i(full_scale_range), .sense_raw_i(sraw), .source_raw_i(vraw),
    .sense_high_limit_i(shl), .sense_low_limit_i({12'h800, 12'h800}),
    .source_high_limit_i({11'h7ff, 11'h7ff}), .source_low_limit_i(vll),
    .high_status_clear_i(hclr), .low_status_clear_i(lclr), .alert_mask_all_i(mall),
    .alert_mask_i(4'h0), .conversion_done_flag_alert_en_i(cdae), .full_scale_range_o(fso),
    .sample_sense_o(ss), .sample_source_o(vs), .standby_o(stby), .busy_o(busy),
    .sense_result_o(sres), .source_result_o(vres), .power_ratio_o(pr),
    .high_status_o(hst), .low_status_o(lst), .alert_o(alrt), .alert_oe_n_o(aoen));

  task automatic final_report();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
    begin
      $display("TB: PASS");
    end
    else
    begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  // sel 0 watches busy, 1 watches standby; n counts falling edges waited
  task automatic wait_for(input int sel, input logic lvl, input int lim, output int n);
    n = 0;
    while (((sel == 1) ? stby : busy) !== lvl)
    begin
      @(negedge sys_clk_i);
      n++;
      if (n > lim)
      begin
        fails++;
        final_report();
      end
    end
  endtask : wait_for

  task automatic one_shot();
    int n;
    osr = 1'b1;
    @(negedge sys_clk_i);
    osr = 1'b0;
    wait_for(0, 1'b1, 20, n);
    wait_for(0, 1'b0, 400, n);
    @(negedge sys_clk_i);
  endtask : one_shot

  task automatic t_reset();
    `CHK({stby, busy, aoen, alrt}, 4'ha)
    `CHK(fso, 2'h3)
    `CHK({sres, vres, pr, hst, lst}, 105'h0)
  endtask : t_reset

  task automatic t_one_shot();
    one_shot();
    `CHK(sres, {16'hc000, 16'h4000})
    `CHK(vres, {16'h8000, 16'h8000})
    `CHK(pr, {16'h4000, 16'h4000})
    `CHK({hst, lst}, 9'h100)
    `CHK(fso, 2'h1)
    `CHK({stby, aoen}, 2'b11)
  endtask : t_one_shot

  task automatic t_alert();
    shl[0] = 12'h100;
    vll[1] = 11'h500;
    one_shot();
    `CHK({hst, lst}, 9'h118)
    `CHK(aoen, 1'b0)
    mall = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    `CHK(aoen, 1'b1)
    mall = 1'b0;
    shl[0] = 12'h7ff;
    vll[1] = 11'h000;
    vlvl[0] = 11'h200;
    vavg[0] = 2'h1;
    one_shot();
    `CHK({aoen, hst, lst}, 10'h118)
    `CHK(vres[0], 16'h6000)
    `CHK(pr[0], 16'h3000)
    hclr = 5'h1f;
    lclr = 4'hf;
    @(negedge sys_clk_i);
    hclr = '0;
    lclr = '0;
    @(negedge sys_clk_i);
    `CHK({aoen, hst, lst}, 10'h200)
    cdae = 1'b1;
    one_shot();
    `CHK({aoen, hst[4]}, 2'b01)
    repeat (100) @(negedge sys_clk_i);
    `CHK(aoen, 1'b1)
    cdae = 1'b0;
  endtask : t_alert

  task automatic t_active();
    int n;
    int gap;
    // rate only ever changes while in standby
    rate = RATE_4;
    dis = 4'h1;
    wait_for(0, 1'b1, 20, n);
    `CHK({ss, vs[0]}, 3'b101)
    wait_for(0, 1'b0, 400, n);
    wait_for(0, 1'b1, 1000, gap);
    `CHK(((n + gap) >= 400) && ((n + gap) <= 401), 1'b1)
    dis = 4'hf;
    wait_for(1, 1'b1, 1000, n);
    stc[1] = 3'h7;
    dis = 4'h1;
    wait_for(0, 1'b1, 20, n);
    wait_for(0, 1'b0, 1000, n);
    wait_for(0, 1'b1, 20, gap);
    `CHK(gap <= 4, 1'b1)
    `CHK(n >= 128 * TICKS, 1'b1)
    dis = 4'hf;
    wait_for(1, 1'b1, 1000, n);
    n = 0;
    repeat (300)
    begin
      @(negedge sys_clk_i);
      n += (busy !== 1'b0);
    end
    `CHK(n, 0)
    `CHK(sres[1], 16'hc000)
  endtask : t_active

  initial
  begin
    repeat (5) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    @(negedge sys_clk_i);
    t_reset();
    t_one_shot();
    t_alert();
    t_active();
    final_report();
  end
endmodule : cpm_sequencer_bench

bind cpm_sequencer cpm_sequencer_props u_cpm_sequencer_props (.sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i), .measurement_disable_flags_i(measurement_disable_flags_i),
  .alert_mask_all_i(alert_mask_all_i), .alert_mask_i(alert_mask_i),
  .conversion_done_flag_alert_en_i(conversion_done_flag_alert_en_i), .high_status_clear_i(high_status_clear_i),
  .low_status_clear_i(low_status_clear_i), .sample_sense_o(sample_sense_o),
  .sample_source_o(sample_source_o), .busy_o(busy_o), .sense_result_o(sense_result_o),
  .source_result_o(source_result_o), .power_ratio_o(power_ratio_o),
  .high_status_o(high_status_o), .low_status_o(low_status_o), .alert_oe_n_o(alert_oe_n_o));

// ===== test/cpm_sequencer_props.sv
// port-level assertions for the conversion sequencer
`timescale 1ns/100ps
module cpm_sequencer_props (
  input wire logic                            sys_clk_i,
  input wire logic                            reset_n_i,
  input wire logic [cpm_pkg::NMEAS-1:0]       measurement_disable_flags_i,
  input wire logic                            alert_mask_all_i,
  input wire logic [cpm_pkg::NMEAS-1:0]       alert_mask_i,
  input wire logic                            conversion_done_flag_alert_en_i,
  input wire logic [cpm_pkg::NMEAS:0]         high_status_clear_i,
  input wire logic [cpm_pkg::NMEAS-1:0]       low_status_clear_i,
  input wire logic [cpm_pkg::NCH-1:0]         sample_sense_o,
  input wire logic [cpm_pkg::NCH-1:0]         sample_source_o,
  input wire logic                            busy_o,
  input wire logic [cpm_pkg::NCH-1:0][15:0]   sense_result_o,
  input wire logic [cpm_pkg::NCH-1:0][15:0]   source_result_o,
  input wire logic [cpm_pkg::NCH-1:0][15:0]   power_ratio_o,
  input wire logic [cpm_pkg::NMEAS:0]         high_status_o,
  input wire logic [cpm_pkg::NMEAS-1:0]       low_status_o,
  input wire logic                            alert_oe_n_o
);
  import cpm_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_full_start;
    $rose(busy_o) && ($past(measurement_disable_flags_i) == 4'hf);
  endsequence
  sequence s_both_sense;
    sample_sense_o == 2'b11;
  endsequence
  a_one_shot_all: assert property (s_full_start |-> s_both_sense)
    else $error("one-shot did not open both sense windows");
  a_sense_pad: assert property ((sense_result_o[0][3:0] | sense_result_o[1][3:0]) == 4'h0)
    else $error("sense result low bits not zero");
  a_source_pad: assert property ((source_result_o[0][4:0] | source_result_o[1][4:0]) == 5'h00)
    else $error("source result low bits not zero");
  a_results_in_cycle: assert property (($changed(sense_result_o) || $changed(source_result_o)
    || $changed(power_ratio_o)) |-> $past(busy_o)) else $error("results changed outside a cycle");
  a_idle_no_window: assert property (!busy_o |-> (sample_sense_o | sample_source_o) == 2'b00)
    else $error("sample window open while idle");
  a_sense_then_source: assert property ((sample_sense_o & sample_source_o) == 2'b00)
    else $error("sense and source windows overlap");
  a_done_in_cycle: assert property ($rose(high_status_o[FLG_CONVERSION_DONE_FLAG]) |-> $past(busy_o))
    else $error("done flag set outside a cycle");
  a_alert_set: assert property ((!alert_mask_all_i && ((((high_status_o[3:0]
    & ~high_status_clear_i[3:0]) | (low_status_o & ~low_status_clear_i)) & ~alert_mask_i)
    != 4'h0)) |=> !alert_oe_n_o) else $error("alert not asserted");
  a_alert_release: assert property ((((high_status_o[3:0] | low_status_o) == 4'h0)
    && !conversion_done_flag_alert_en_i && !busy_o) |=> alert_oe_n_o) else $error("alert held without flags");
endmodule : cpm_sequencer_props
